// *** rtl/wdt_pkg.sv ***
/*
 * constants shared by the watchdog block: register indexes, field positions,
 * reset values and the divider ratio from the low-speed oscillator.
 * assumes a 32-bit classic wishbone bus with byte addresses.
 */
package wdt_pkg;
	// ==========================================================
	// register map (word index; byte address is four times it)
	localparam logic [15:0] CTRL_IDX = 16'hff07;
	localparam logic [15:0] STAT_IDX = 16'hff10;
	localparam logic [15:0] CLR_IDX = 16'hff11;
	localparam logic [15:0] IEN_IDX = 16'hff12;
	localparam logic [15:0] CNT_IDX = 16'hff13;
	// ==========================================================
	// control register fields
	localparam int RESTART_BIT = 0;
	localparam int ENABLE_BIT = 1;
	localparam logic ENABLE_RST = 1'h1;
	// ==========================================================
	// status / clear / enable fields
	localparam int ST_OVF_BIT = 0;
	localparam int ST_ACC_BIT = 1;
	localparam int ST_W = 2;
	localparam logic [1:0] ST_RST = 2'h0;
	localparam logic [1:0] IEN_RST = 2'h0;
	// ==========================================================
	// counter and timing
	localparam int CNT_W = 10;
	localparam logic [9:0] CNT_RST = 10'h000;
	localparam logic [9:0] CNT_LAST = 10'h3ff;
	localparam int OSC_HZ = 32768;
	localparam int TICK_HZ = 256;
	localparam int OSC_DIV = OSC_HZ / TICK_HZ;
	localparam logic [15:0] NMI_VECTOR = 16'h0100;
endpackage

// *** rtl/wdt_prescaler.sv ***
/*
 * divides the synchronised low-speed oscillator edges down to a one-cycle
 * tick enable. assumes step_i is already a one-cycle pulse on clk_i.
 */
`timescale 1ns/1ps
module wdt_prescaler #(
	parameter logic [7:0] DIV = 8'h80
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// oscillator edge in, tick out
	input wire logic step_i,
	output logic tick_o
);
	logic [7:0] div_reg;

	// ==========================================================
	// divider: free running, so a restart never shifts its phase
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_reg <= 8'h00;
			tick_o <= 1'b0;
		end else begin
			tick_o <= 1'b0;
			if (step_i) begin
				if (div_reg == DIV - 8'h01) begin
					div_reg <= 8'h00;
					tick_o <= 1'b1;
				end else begin
					div_reg <= div_reg + 8'h01;
				end
			end
		end
	end
endmodule

// *** rtl/wdt_top.sv ***
/*
 * watchdog with non-maskable interrupt: a 10-bit counter stepped at the
 * low-speed oscillator rate divided down, a control register, and an
 * interrupt status block, all over a classic wishbone slave.
 * assumes the oscillator pin is asynchronous and much slower than clk_i,
 * and that the core reports stack pointer half loads and nmi acceptance.
 */
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
module wdt_top #(
	parameter logic [7:0] OSC_DIV = 8'(wdt_pkg::OSC_DIV)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [17:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// oscillator pin
	input wire logic low_speed_oscillator_i,
	// core side
	input wire logic stack_pointer_low_half_wr_i,
	input wire logic stack_pointer_high_half_wr_i,
	input wire logic nmi_ack_i,
	output logic nmi_req_o,
	output logic [15:0] nmi_vector_o,
	// interrupt to system
	output logic irq_o
);
	logic osc_s1_reg;
	logic osc_s2_reg;
	logic osc_s3_reg;
	logic osc_lvl_reg;
	logic osc_rise;
	logic tick;
	logic [wdt_pkg::CNT_W-1:0] count_reg;
	logic count_enable_reg;
	logic ovf_reg;
	logic nmi_pend_reg;
	logic sp_low_reg;
	logic sp_high_reg;
	logic pair_ok;
	logic [wdt_pkg::ST_W-1:0] stat_reg;
	logic [wdt_pkg::ST_W-1:0] ien_reg;
	logic [15:0] idx;
	logic req;
	logic wr;
	logic rd;
	logic restart;
	logic clr_wr;
	logic [31:0] rdata;
	logic accept;

	// ==========================================================
	// oscillator pin synchroniser
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_s1_reg <= 1'b0;
			osc_s2_reg <= 1'b0;
			osc_s3_reg <= 1'b0;
			osc_lvl_reg <= 1'b0;
		end else begin
			osc_s1_reg <= low_speed_oscillator_i;
			osc_s2_reg <= osc_s1_reg;
			osc_s3_reg <= osc_s2_reg;
			if (osc_s2_reg == osc_s3_reg) begin
				osc_lvl_reg <= osc_s3_reg;
			end
		end
	end

	// a new level counts only once two stages agree, so glitches do not step
	assign osc_rise = osc_s2_reg & osc_s3_reg & ~osc_lvl_reg;

	wdt_prescaler #(
		.DIV(OSC_DIV)
	) u_presc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(osc_rise),
		.tick_o(tick)
	);

	// ==========================================================
	// bus decode
	assign idx = wb_adr_i[17:2];
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = req & wb_we_i & wb_sel_i[0];
	assign rd = req & ~wb_we_i;
	assign restart = wr & (idx == wdt_pkg::CTRL_IDX) & wb_dat_i[wdt_pkg::RESTART_BIT];
	assign clr_wr = wr & (idx == wdt_pkg::CLR_IDX);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	always_comb begin
		rdata = 32'h0000_0000;
		unique case (idx)
			wdt_pkg::CTRL_IDX: rdata[wdt_pkg::ENABLE_BIT] = count_enable_reg;
			wdt_pkg::STAT_IDX: rdata[wdt_pkg::ST_W-1:0] = stat_reg;
			wdt_pkg::IEN_IDX: rdata[wdt_pkg::ST_W-1:0] = ien_reg;
			wdt_pkg::CNT_IDX: rdata[wdt_pkg::CNT_W-1:0] = count_reg;
			default: rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			wb_dat_o <= rdata;
		end else begin
			wb_dat_o <= 32'h0000_0000;
		end
	end

	// ==========================================================
	// control register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_enable_reg <= wdt_pkg::ENABLE_RST;
		end else if (wr && idx == wdt_pkg::CTRL_IDX) begin
			count_enable_reg <= wb_dat_i[wdt_pkg::ENABLE_BIT];
		end
	end

	// ==========================================================
	// counter: runs regardless of core halt, which it never sees
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_reg <= wdt_pkg::CNT_RST;
			ovf_reg <= 1'b0;
		end else begin
			ovf_reg <= 1'b0;
			if (restart) begin
				count_reg <= wdt_pkg::CNT_RST;
			end else if (tick && count_enable_reg) begin
				count_reg <= count_reg + 10'h001;
				ovf_reg <= (count_reg == wdt_pkg::CNT_LAST);
			end
		end
	end

	// ==========================================================
	// stack pointer pair tracking: reloading either half blocks the nmi
	assign pair_ok = sp_low_reg & sp_high_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_low_reg <= 1'b0;
			sp_high_reg <= 1'b0;
		end else begin
			if (stack_pointer_low_half_wr_i) begin
				sp_low_reg <= 1'b1;
				if (pair_ok) begin
					sp_high_reg <= 1'b0;
				end
			end
			if (stack_pointer_high_half_wr_i) begin
				sp_high_reg <= 1'b1;
				if (pair_ok) begin
					sp_low_reg <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// nmi request: pending survives until accepted or counting is disabled; no mask input exists
	assign accept = nmi_req_o & nmi_ack_i;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_pend_reg <= 1'b0;
		end else if (ovf_reg) begin
			nmi_pend_reg <= 1'b1;
		end else if (accept || !count_enable_reg) begin
			nmi_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_req_o <= 1'b0;
		end else begin
			nmi_req_o <= nmi_pend_reg & pair_ok & ~accept & ~ovf_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_vector_o <= wdt_pkg::NMI_VECTOR;
		end else begin
			nmi_vector_o <= wdt_pkg::NMI_VECTOR;
		end
	end

	// ==========================================================
	// system interrupt status, enable and clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stat_reg <= wdt_pkg::ST_RST;
		end else begin
			for (int i = 0; i < wdt_pkg::ST_W; i++) begin
				if (i == wdt_pkg::ST_OVF_BIT && ovf_reg) begin
					stat_reg[i] <= 1'b1;
				end else if (i == wdt_pkg::ST_ACC_BIT && accept) begin
					stat_reg[i] <= 1'b1;
				end else if (clr_wr && wb_dat_i[i]) begin
					stat_reg[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ien_reg <= wdt_pkg::IEN_RST;
		end else if (wr && idx == wdt_pkg::IEN_IDX) begin
			ien_reg <= wb_dat_i[wdt_pkg::ST_W-1:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(stat_reg & ien_reg);
		end
	end

	// ==========================================================
	// checks
	property p_step_cause;
		@(posedge clk_i) disable iff (rst_i)
		(count_reg != $past(count_reg)) && !$past(restart) |-> $past(tick) && $past(count_enable_reg);
	endproperty
	a_step_cause: assert property (p_step_cause) else $error("counter moved without tick");

	property p_enable_after_reset;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> count_enable_reg && count_reg == 10'h000;
	endproperty
	a_enable_after_reset: assert property (p_enable_after_reset) else $error("not counting after reset");

	property p_overflow;
		@(posedge clk_i) disable iff (rst_i)
		ovf_reg |-> $past(count_reg) == 10'h3ff && count_reg == 10'h000 && $past(tick);
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow at wrong count");

	property p_ovf_pending;
		@(posedge clk_i) disable iff (rst_i)
		ovf_reg |=> nmi_pend_reg;
	endproperty
	a_ovf_pending: assert property (p_ovf_pending) else $error("overflow lost");

	property p_pair_gate;
		@(posedge clk_i) disable iff (rst_i)
		nmi_req_o |-> $past(sp_low_reg) && $past(sp_high_reg);
	endproperty
	a_pair_gate: assert property (p_pair_gate) else $error("nmi before stack pointer pair");

	property p_disabled_hold;
		@(posedge clk_i) disable iff (rst_i)
		!count_enable_reg && !restart |=> count_reg == $past(count_reg) && !ovf_reg;
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("counting while disabled");

	property p_restart;
		@(posedge clk_i) disable iff (rst_i)
		restart |=> count_reg == 10'h000 && !ovf_reg;
	endproperty
	a_restart: assert property (p_restart) else $error("restart did not clear");

	property p_ctrl_read;
		@(posedge clk_i) disable iff (rst_i)
		rd && idx == wdt_pkg::CTRL_IDX |=> wb_ack_o && wb_dat_o[0] == 1'b0 && wb_dat_o[31:2] == 30'h0;
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read shows write-only bits");

	property p_single;
		@(posedge clk_i) disable iff (rst_i)
		ovf_reg |=> !ovf_reg;
	endproperty
	a_single: assert property (p_single) else $error("overflow lasted two cycles");
endmodule

// *** verification/tb_watchdog_nmi_timer.sv ***
/*
 * bench for the watchdog: wishbone tasks, an oscillator source and a core model.
 * assumes OSC_DIV is set to 2 and the pin toggles every 8 clocks (one step per 32).
 */
`timescale 1ns/1ps
module tb_watchdog_nmi_timer;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [17:0] wb_adr_i = 18'h00000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic osc = 1'b0;
	logic [2:0] osc_div = 3'h0;
	logic sp_lo, sp_hi, nmi_ack, nmi_req, irq_o;
	logic [15:0] nmi_vec, vec_seen;
	logic load_sp = 1'b0;
	logic accept_en = 1'b0;
	logic [31:0] rd, cnt0;
	int n_mismatch = 0;
	int num_checks = 0;
	int cycles = 0;
	int t0;
	// ==========================================================
	// clock, oscillator pin and hang guard
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		osc_div <= osc_div + 3'h1;
		if (osc_div == 3'h7) osc <= ~osc;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch = n_mismatch + 1;
			tally_and_finish();
		end
	end
	wdt_top #(.OSC_DIV(8'h02)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .low_speed_oscillator_i(osc), .stack_pointer_low_half_wr_i(sp_lo),
		.stack_pointer_high_half_wr_i(sp_hi), .nmi_ack_i(nmi_ack), .nmi_req_o(nmi_req),
		.nmi_vector_o(nmi_vec), .irq_o(irq_o));
	wdt_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .load_sp_i(load_sp), .accept_en_i(accept_en),
		.nmi_req_i(nmi_req), .nmi_vector_i(nmi_vec), .sp_lo_o(sp_lo), .sp_hi_o(sp_hi), .nmi_ack_o(nmi_ack),
		.vec_seen_o(vec_seen));
	// ==========================================================
	// bus tasks and comparisons
	task automatic wb(input logic we, input logic [15:0] idx, input logic [3:0] sel, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx, 2'h0};
		wb_sel_i <= sel;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 100);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		if (n >= 100) n_mismatch++;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rdchk(input string nm, input logic [15:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 4'hf, 32'h0);
		chk(nm, e, rd);
	endtask
	// count reads land in rd for range checks; only the ten counter bits may be set
	task automatic rdcnt();
		wb(1'b0, wdt_pkg::CNT_IDX, 4'hf, 32'h0);
		chk("count upper", 32'h0, rd & 32'hffff_fc00);
	endtask
	task automatic rng(input string nm, input logic [31:0] v, input int lo, input int hi);
		chk(nm, 32'h1, {31'h0, (v >= lo && v <= hi)});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// tests
	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk("ctrl", wdt_pkg::CTRL_IDX, 32'h2);
		rdchk("stat", wdt_pkg::STAT_IDX, 32'h0);
		rdchk("unmapped", 16'h0000, 32'h0);
		chk("vector", 32'h0100, {16'h0, nmi_vec});
		repeat (640) @(posedge clk_i);
		rdcnt();
		rng("count runs", rd, 15, 25);
		wb(1'b1, wdt_pkg::CTRL_IDX, 4'hf, 32'h3);
		rdcnt();
		rng("restart", rd, 0, 1);
		repeat (320) @(posedge clk_i);
		rdcnt();
		cnt0 = rd;
		rng("rate", cnt0, 9, 12);
		wb(1'b1, wdt_pkg::CTRL_IDX, 4'hf, 32'h2);
		rdcnt();
		rng("no restart", rd, cnt0, cnt0 + 2);
		wb(1'b1, wdt_pkg::CTRL_IDX, 4'he, 32'h0);
		rdchk("sel ignored", wdt_pkg::CTRL_IDX, 32'h2);
		wb(1'b1, wdt_pkg::CTRL_IDX, 4'hf, 32'h0);
		rdcnt();
		cnt0 = rd;
		repeat (320) @(posedge clk_i);
		rdchk("held", wdt_pkg::CNT_IDX, cnt0);
		rdchk("ctrl off", wdt_pkg::CTRL_IDX, 32'h0);
		wb(1'b1, wdt_pkg::CTRL_IDX, 4'hf, 32'h3);
		t0 = cycles;
		do wb(1'b0, wdt_pkg::STAT_IDX, 4'hf, 32'h0);
		while (rd[0] !== 1'b1 && cycles < 59000);
		rng("timeout", cycles - t0, 32704, 32800);
		chk("nmi held off", 32'h0, {31'h0, nmi_req});
		chk("irq masked", 32'h0, {31'h0, irq_o});
		wb(1'b1, wdt_pkg::IEN_IDX, 4'hf, 32'h1);
		// irq_o is registered one cycle behind the enable write
		@(posedge clk_i);
		chk("irq", 32'h1, {31'h0, irq_o});
		@(posedge clk_i);
		load_sp <= 1'b1;
		@(posedge clk_i);
		load_sp <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk("nmi after pair", 32'h1, {31'h0, nmi_req});
		accept_en <= 1'b1;
		repeat (6) @(posedge clk_i);
		rdchk("stat acc", wdt_pkg::STAT_IDX, 32'h3);
		chk("vector seen", 32'h0100, {16'h0, vec_seen});
		wb(1'b1, wdt_pkg::CLR_IDX, 4'hf, 32'h3);
		rdchk("stat clr", wdt_pkg::STAT_IDX, 32'h0);
		chk("irq clr", 32'h0, {31'h0, irq_o});
		rdcnt();
		rng("wrapped", rd, 0, 15);
		repeat (100) @(posedge clk_i);
		chk("one nmi", 32'h0, {31'h0, nmi_req});
		tally_and_finish();
	end
endmodule

// *** verification/wdt_core_model.sv ***
/*
 * core model at the far end of the nmi: loads the stack pointer pair on
 * command, accepts the nmi while allowed and keeps the vector it saw.
 * assumes nmi_req_i is a level held until acknowledged.
 */
`timescale 1ns/1ps
module wdt_core_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bench commands
	input wire logic load_sp_i,
	input wire logic accept_en_i,
	// nmi side
	input wire logic nmi_req_i,
	input wire logic [15:0] nmi_vector_i,
	output logic sp_lo_o,
	output logic sp_hi_o,
	output logic nmi_ack_o,
	output logic [15:0] vec_seen_o
);
	// ==========================================================
	// low half first, high half next cycle: the pair is whole only after both
	always_ff @(posedge clk_i) begin
		sp_lo_o <= load_sp_i & ~rst_i;
		sp_hi_o <= sp_lo_o & ~rst_i;
	end
	// ==========================================================
	// only accept_en_i and the previous cycle's nmi_ack_o gate acceptance: no other flag masks the request here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nmi_ack_o <= 1'b0;
			vec_seen_o <= 16'h0000;
		end else begin
			nmi_ack_o <= nmi_req_i & accept_en_i & ~nmi_ack_o;
			if (nmi_req_i & accept_en_i & ~nmi_ack_o) begin
				vec_seen_o <= nmi_vector_i;
			end
		end
	end
endmodule
